// ==== pkg/tsync_pkg.sv ====
/*
  Shared constants of the time synchronisation core: register offsets,
  status bit positions, link code classes and averaging constants.
  Assumes a byte-addressed register port with 8 address bits.
*/
package tsync_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register port
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RATE_STEP = 8'h04;
  localparam logic [7:0] OFS_TIME_STEP = 8'h08;
  localparam logic [7:0] OFS_GAIN = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_MAP = 8'h14;
  localparam logic [7:0] OFS_LATENCY = 8'h18;
  localparam logic [7:0] OFS_TLOAD_LO = 8'h1C;
  localparam logic [7:0] OFS_TLOAD_HI = 8'h20;
  localparam logic [7:0] OFS_LTIME = 8'h24;
  localparam logic [7:0] OFS_TRIM = 8'h28;

  // control register bits
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_SEND_DI = 1;

  ////////////////////////////////////////////////////////////////////////
  // status flags
  localparam int FLAG_W = 6;
  localparam int FLAG_SYNC = 0;
  localparam int FLAG_TC_RX = 1;
  localparam int FLAG_TM_DUE = 2;
  localparam int FLAG_TC_TX = 3;
  localparam int FLAG_DI_RX = 4;
  localparam int FLAG_DI_TX = 5;
  localparam logic [5:0] FLAGS_RESET = 6'h00;

  ////////////////////////////////////////////////////////////////////////
  // link codes: upper two bits give the class, low six the value
  localparam logic [1:0] CODE_TIME = 2'h0;
  localparam logic [1:0] CODE_DIST_INT = 2'h2;

  // measurement and averaging
  localparam int CNT_W = 16;
  localparam int AVG_SHIFT = 2;
  localparam int SPREAD_W = 3;
  localparam int GAIN_W = 24;

endpackage

// ==== pkg/meas_if.sv ====
/*
  Carrier for one tick period measurement: the latest period in clock
  cycles and a one-cycle pulse when it is refreshed.
  Assumes the meter and its reader share the system clock.
*/
`timescale 1ns/1ps
interface meas_if #(parameter int CNT_W = 16);
  logic [CNT_W-1:0] period;
  logic valid;
  modport meter (output period, output valid);
  modport core (input period, input valid);
endinterface

// ==== rtl/tick_meter.sv ====
/*
  Counts system clocks between successive ticks and reports the period.
  Assumes tick_i is a one-cycle pulse from logic on the same clock.
*/
`timescale 1ns/1ps
module tick_meter #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // tick to measure
  input wire logic tick_i,
  // result
  meas_if.meter m
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] period;
    logic seen;
    logic valid;
  } meter_type;

  meter_type r;
  meter_type next_r;

  ////////////////////////////////////////////////////////////////////////
  // count saturates, but a tick after saturation reports a period that wraps to zero
  always_comb begin
    next_r = r;
    next_r.valid = 1'b0;
    if (r.count != {CNT_W{1'b1}}) begin
      next_r.count = r.count + 1'b1;
    end
    if (tick_i) begin
      next_r.count = '0;
      next_r.seen = 1'b1;
      // first tick only opens the window
      if (r.seen) begin
        next_r.period = CNT_W'(r.count + 1'b1);
        next_r.valid = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign m.period = r.period;
  assign m.valid = r.valid;

  a_period_valid: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    tick_i && r.seen |=> m.valid && m.period == $past(r.count) + 1'b1)
    else $error("period not reported after tick");

endmodule

// ==== rtl/time_sync_correction.sv ====
/*
  Time synchronisation core: local elapsed time driven by a rate
  accumulator, disciplined to time-codes from a remote initiator.
  Assumes a link codec on the same clock that answers each request with
  a completion pulse and reports arrivals as one-cycle events.
*/
`timescale 1ns/1ps
module time_sync_correction import tsync_pkg::*; #(
  parameter bit MITIGATION = 1'b0,
  parameter int COARSE_BITS = 32,
  parameter int FINE_BITS = 24,
  parameter int ACC_W = 30,
  parameter logic [29:0] RATE_STEP_DEF = 30'h15798EE2,
  parameter logic [7:0] TIME_STEP_DEF = 8'h00,
  parameter logic [23:0] GAIN_DEF = 24'h0001CD,
  parameter logic [4:0] MAP_DEF = 5'h06,
  parameter bit IS_INITIATOR = 1'b0,
  parameter bit IS_TARGET = 1'b0,
  parameter int DELAY_EXP = 9,
  parameter int PINDEX = 0
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  // from link codec
  input wire logic tick_in_done_i,
  input wire logic tick_out_raw_i,
  input wire logic [7:0] time_out_i,
  // to link codec
  output logic tick_in_raw_o,
  output logic [7:0] time_in_o,
  output logic [COARSE_BITS+FINE_BITS-1:0] elapsed_time_o,
  output logic enable_o,
  // diagnostics
  output logic diag_ctick_o,
  output logic diag_jtick_o
);

  localparam int TW = COARSE_BITS + FINE_BITS;
  localparam int SW = ACC_W + 2;
  localparam logic [15:0] DELAY_CYC = 16'(1 << DELAY_EXP);

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic [TW-1:0] ltime;
    logic [TW-1:0] etime;
    logic [ACC_W-1:0] rate_step;
    logic signed [SW-1:0] trim;
    logic signed [SW-1:0] spread;
    logic signed [SW-1:0] spread_inc;
    logic [SPREAD_W-1:0] spread_cnt;
    logic [7:0] time_step;
    logic [GAIN_W-1:0] gain;
    logic [4:0] map;
    logic enable;
    logic [31:0] latency;
    logic [31:0] tload_lo;
    logic [FLAG_W-1:0] flags;
    logic [31:0] prdata;
    logic tick_in_raw;
    logic [7:0] time_in;
    logic ctick;
    logic jtick;
    logic lbit_q;
    logic [CNT_W-1:0] since_local;
    logic signed [CNT_W-1:0] favg;
    logic signed [CNT_W+SPREAD_W-1:0] jsum;
    logic [SPREAD_W-1:0] jcnt;
    logic di_pend;
    logic busy;
    logic busy_di;
    logic [15:0] delay_cnt;
  } state_type;

  state_type r;
  state_type next_r;

  meas_if #(.CNT_W(CNT_W)) lmeas ();
  meas_if #(.CNT_W(CNT_W)) emeas ();

  logic [ACC_W-1:0] step_eff;
  logic [ACC_W:0] acc_sum;
  logic wrap;
  logic ltick;
  logic ext_tick;
  logic code_is_tc;
  logic code_is_di;
  logic apb_wr;
  logic apb_setup;
  logic [5:0] code_val;
  logic signed [CNT_W-1:0] phase;
  logic signed [CNT_W-1:0] fdiff;
  logic signed [CNT_W-1:0] favg_new;
  logic signed [CNT_W+SPREAD_W-1:0] jsum_new;
  logic signed [SW-1:0] corr;
  logic [FLAG_W-1:0] set_f;
  logic [FLAG_W-1:0] clr_f;

  ////////////////////////////////////////////////////////////////////////
  // period meters for local and external ticks
  tick_meter #(.CNT_W(CNT_W)) u_local_meter (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .tick_i(ltick),
    .m(lmeas.meter)
  );

  tick_meter #(.CNT_W(CNT_W)) u_ext_meter (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .tick_i(ext_tick),
    .m(emeas.meter)
  );

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    next_r = r;
    next_r.tick_in_raw = 1'b0;
    next_r.ctick = 1'b0;
    next_r.jtick = 1'b0;
    set_f = '0;
    phase = '0;
    fdiff = '0;
    favg_new = r.favg;
    jsum_new = r.jsum;
    corr = '0;
    apb_setup = psel_i && !penable_i;
    apb_wr = psel_i && penable_i && pwrite_i;
    code_is_tc = time_out_i[7:6] == CODE_TIME;
    code_is_di = time_out_i[7:6] == CODE_DIST_INT;
    // trim and spread never include latency, only tick corrections
    step_eff = ACC_W'($signed({2'b00, r.rate_step}) + r.trim + r.spread);
    acc_sum = {1'b0, r.acc} + {1'b0, step_eff};
    wrap = acc_sum[ACC_W];
    next_r.acc = acc_sum[ACC_W-1:0];
    if (wrap) begin
      next_r.ltime = TW'(r.ltime + TW'(r.time_step));
    end
    // local tick when the mapped bit of local time falls from one to zero
    next_r.lbit_q = r.ltime[r.map];
    ltick = r.lbit_q && !r.ltime[r.map];
    code_val = 6'(r.ltime >> r.map);
    ext_tick = IS_TARGET && r.enable && tick_out_raw_i && code_is_tc;
    // latency is added to the output only
    next_r.etime = TW'(r.ltime + TW'(r.latency));

    // cycles since the last local tick, saturating
    if (ltick) begin
      next_r.since_local = '0;
    end else if (r.since_local != {CNT_W{1'b1}}) begin
      next_r.since_local = r.since_local + 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // arrivals from the codec
    if (ext_tick) begin
      set_f[FLAG_TC_RX] = 1'b1;
      next_r.jtick = 1'b1;
    end
    if (tick_out_raw_i && code_is_di) begin
      set_f[FLAG_DI_RX] = 1'b1;
    end

    // phase: external late means local is fast, so slow it down
    if (ext_tick && lmeas.period != '0) begin
      phase = $signed(r.since_local);
      if (r.since_local > (lmeas.period >> 1)) begin
        phase = $signed(r.since_local - lmeas.period);
      end
      if (!MITIGATION) begin
        corr = SW'($signed({1'b0, r.gain}) * phase);
        next_r.trim = r.trim - corr;
      end else begin
        // average over a window, apply at once, then spread it out
        jsum_new = r.jsum + (CNT_W+SPREAD_W)'(phase);
        next_r.jsum = jsum_new;
        next_r.jcnt = r.jcnt + 1'b1;
        if (r.jcnt == {SPREAD_W{1'b1}}) begin
          corr = SW'($signed({1'b0, r.gain}) * (jsum_new >>> SPREAD_W));
          next_r.trim = r.trim - (corr >>> SPREAD_W);
          next_r.spread = -corr;
          next_r.spread_inc = corr >>> SPREAD_W;
          next_r.spread_cnt = {SPREAD_W{1'b1}};
          next_r.jsum = '0;
        end
      end
    end else if (MITIGATION && ltick && r.spread_cnt != '0) begin
      next_r.spread = r.spread + r.spread_inc;
      next_r.spread_cnt = r.spread_cnt - 1'b1;
      if (r.spread_cnt == SPREAD_W'(1)) begin
        next_r.spread = '0;
      end
    end

    // frequency: local period longer than external means local is slow
    if (emeas.valid && lmeas.period != '0) begin
      fdiff = $signed(lmeas.period - emeas.period);
      favg_new = r.favg + ((fdiff - r.favg) >>> AVG_SHIFT);
      next_r.favg = favg_new;
      next_r.trim = next_r.trim + SW'($signed({1'b0, r.gain}) * favg_new);
    end

    ////////////////////////////////////////////////////////////////////
    // transmit side: one request in flight at a time
    if (r.delay_cnt != '0) begin
      next_r.delay_cnt = r.delay_cnt - 1'b1;
    end
    if (r.busy && tick_in_done_i) begin
      next_r.busy = 1'b0;
      set_f[FLAG_DI_TX] = r.busy_di;
    end
    if (ltick && r.enable) begin
      next_r.ctick = 1'b1;
      if (IS_INITIATOR && !r.busy) begin
        next_r.tick_in_raw = 1'b1;
        next_r.time_in = {CODE_TIME, code_val};
        next_r.busy = 1'b1;
        next_r.busy_di = 1'b0;
        next_r.delay_cnt = DELAY_CYC;
        set_f[FLAG_TC_TX] = 1'b1;
        set_f[FLAG_TM_DUE] = code_val == '0;
      end
    end else if (r.di_pend && !r.busy && r.delay_cnt == '0) begin
      next_r.tick_in_raw = 1'b1;
      next_r.time_in = {CODE_DIST_INT, 6'h00};
      next_r.busy = 1'b1;
      next_r.busy_di = 1'b1;
      next_r.di_pend = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // register writes
    clr_f = '0;
    if (apb_wr) begin
      case (paddr_i)
        OFS_CTRL: begin
          next_r.enable = pwdata_i[CTRL_ENABLE];
          if (pwdata_i[CTRL_SEND_DI]) begin
            next_r.di_pend = 1'b1;
          end
        end
        OFS_RATE_STEP: next_r.rate_step = pwdata_i[ACC_W-1:0];
        OFS_TIME_STEP: next_r.time_step = pwdata_i[7:0];
        OFS_GAIN: next_r.gain = pwdata_i[GAIN_W-1:0];
        OFS_STATUS: clr_f = pwdata_i[FLAG_W-1:0];
        OFS_MAP: next_r.map = pwdata_i[4:0];
        OFS_LATENCY: next_r.latency = pwdata_i;
        OFS_TLOAD_LO: next_r.tload_lo = pwdata_i;
        OFS_TLOAD_HI: begin
          // time message: target takes the initiator's time
          next_r.ltime = TW'({pwdata_i, r.tload_lo});
          set_f[FLAG_SYNC] = IS_TARGET;
        end
        default: begin
        end
      endcase
    end
    // a flag set in the clearing cycle survives
    next_r.flags = (r.flags & ~clr_f) | set_f;

    // read data captured in the setup phase, valid in the access phase
    if (apb_setup) begin
      case (paddr_i)
        OFS_CTRL: next_r.prdata = 32'(r.enable);
        OFS_RATE_STEP: next_r.prdata = 32'(r.rate_step);
        OFS_TIME_STEP: next_r.prdata = 32'(r.time_step);
        OFS_GAIN: next_r.prdata = 32'(r.gain);
        OFS_STATUS: next_r.prdata = 32'(r.flags);
        OFS_MAP: next_r.prdata = 32'(r.map);
        OFS_LATENCY: next_r.prdata = r.latency;
        OFS_TLOAD_LO: next_r.prdata = r.tload_lo;
        OFS_LTIME: next_r.prdata = 32'(r.ltime);
        OFS_TRIM: next_r.prdata = 32'(r.trim);
        default: next_r.prdata = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register; reset loads the build defaults
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
      r.rate_step <= ACC_W'(RATE_STEP_DEF);
      r.time_step <= TIME_STEP_DEF;
      r.gain <= GAIN_DEF;
      r.map <= MAP_DEF;
      r.flags <= FLAGS_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign prdata_o = r.prdata;
  assign tick_in_raw_o = r.tick_in_raw;
  assign time_in_o = r.time_in;
  assign elapsed_time_o = r.etime;
  assign enable_o = r.enable;
  assign diag_ctick_o = r.ctick;
  assign diag_jtick_o = r.jtick;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // cycles since the last time-code request left the block
  logic [15:0] tc_gap;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tc_gap <= 16'hFFFF;
    end else if (tick_in_raw_o && time_in_o[7:6] == CODE_TIME) begin
      tc_gap <= 16'h0000;
    end else if (tc_gap != 16'hFFFF) begin
      tc_gap <= tc_gap + 1'b1;
    end
  end

  a_flags_reset: assert property ($past(!rst_n_i) |-> r.flags == '0)
    else $error("flags not clear after reset");
  a_w1c_clear: assert property (apb_wr && paddr_i == OFS_STATUS &&
    pwdata_i[FLAG_DI_RX] && !(tick_out_raw_i && code_is_di)
    |=> !r.flags[FLAG_DI_RX])
    else $error("status flag not cleared by one");
  a_rx_flag: assert property (ext_tick |=> r.flags[FLAG_TC_RX] ##1
    r.flags[FLAG_TC_RX] || $past(clr_f[FLAG_TC_RX]))
    else $error("time-code arrival not flagged");
  a_jitter_tick: assert property (ext_tick |=> diag_jtick_o ##1
    (!diag_jtick_o || $past(ext_tick)))
    else $error("jitter tick missing");
  a_wrap_step: assert property (wrap && !(apb_wr && paddr_i == OFS_TLOAD_HI)
    |=> r.ltime == TW'($past(r.ltime) + TW'($past(r.time_step))))
    else $error("local time not stepped on wrap");
  a_latency_step: assert property (apb_wr && paddr_i == OFS_LATENCY &&
    !ext_tick && !emeas.valid |=> $stable(r.trim))
    else $error("latency write changed the step");
  a_di_delay: assert property (tick_in_raw_o &&
    time_in_o[7:6] == CODE_DIST_INT |-> tc_gap >= DELAY_CYC)
    else $error("interrupt sent too soon after time-code");
  a_req_pulse: assert property (tick_in_raw_o |=> !tick_in_raw_o ##1
    (!tick_in_raw_o || $past(tick_in_done_i, 2)))
    else $error("request not a single pulse");
  a_ctrl_tick: assert property (tick_in_raw_o &&
    time_in_o[7:6] == CODE_TIME |-> diag_ctick_o)
    else $error("control tick missing on time-code send");
  a_reset_defaults: assert property ($past(!rst_n_i) |-> r.gain == GAIN_DEF &&
    r.time_step == TIME_STEP_DEF)
    else $error("gain or time step not at default");

  c_ext_tick: cover property (ext_tick ##[1:4] emeas.valid);
  c_di_sent: cover property (tick_in_raw_o && time_in_o[7:6] == CODE_DIST_INT
    ##[1:20] tick_in_done_i);
  c_time_load: cover property (apb_wr && paddr_i == OFS_TLOAD_HI);

endmodule

// ==== dv/codec_model.sv ====
/*
  Behavioural link codec facing the time synchronisation core.
  Assumes one system clock; answers each send request lag_i + 1 cycles after it
  and emits arrival events on demand through its emit task.
*/
`timescale 1ns/1ps
module codec_model (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // requests from the core
  input wire logic tick_in_raw_i,
  input wire logic [7:0] time_in_i,
  input wire logic [3:0] lag_i,
  // answers and events to the core
  output logic tick_in_done_o,
  output logic tick_out_raw_o,
  output logic [7:0] time_out_o
);
  logic busy;
  logic [3:0] wait_cnt;

  ////////////////////////////////////////////////////////////////////////
  // one completion pulse per request, after a settable lag
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy <= 1'b0;
      wait_cnt <= 4'h0;
      tick_in_done_o <= 1'b0;
    end else begin
      tick_in_done_o <= 1'b0;
      if (tick_in_raw_i) begin
        busy <= 1'b1;
        wait_cnt <= lag_i;
      end else if (busy && wait_cnt == 4'h0) begin
        busy <= 1'b0;
        tick_in_done_o <= 1'b1;
      end else if (busy) begin
        wait_cnt <= wait_cnt - 4'h1;
      end
    end
  end

  // idle code line starts at zero, then shows the inverse of the last code, so a stale value never matches
  initial begin
    tick_out_raw_o = 1'b0;
    time_out_o = 8'h00;
  end

  // one-cycle arrival event with its code
  task automatic emit(input logic [7:0] code);
    @(negedge mclk_i);
    tick_out_raw_o = 1'b1;
    time_out_o = code;
    @(negedge mclk_i);
    tick_out_raw_o = 1'b0;
    time_out_o = ~code;
  endtask
endmodule

// ==== dv/testbench.sv ====
/*
  Self-checking bench for the time synchronisation core as a target.
  Assumes the codec model answers requests and that the bench drives the
  register port at falling edges.
*/
`timescale 1ns/1ps
module testbench import tsync_pkg::*;;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic pwrite_i = 1'b0;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic done, ev_raw, tick_raw, en, ctick, jtick;
  logic [7:0] ev_code, code_in;
  logic [55:0] et, e0;
  logic [3:0] lag = 4'h0;
  logic [31:0] rd_q;
  int n_fail = 0;
  int cmp_count = 0;
  int jt_cnt = 0;
  int ct_cnt = 0;
  int di_cnt = 0;
  int c0, i;

  always #5 mclk_i = ~mclk_i;

  time_sync_correction #(.IS_TARGET(1'b1), .DELAY_EXP(2))
    time_sync_correction_i (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .paddr_i(paddr_i), .pwrite_i(pwrite_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .tick_in_done_i(done),
    .tick_out_raw_i(ev_raw), .time_out_i(ev_code),
    .tick_in_raw_o(tick_raw), .time_in_o(code_in),
    .elapsed_time_o(et), .enable_o(en), .diag_ctick_o(ctick),
    .diag_jtick_o(jtick));

  codec_model codec_model_i (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .tick_in_raw_i(tick_raw),
    .time_in_i(code_in), .lag_i(lag), .tick_in_done_o(done),
    .tick_out_raw_o(ev_raw), .time_out_o(ev_code));

  // pulse counters, so checks do not hinge on exact cycle alignment
  always @(posedge mclk_i) begin
    if (jtick === 1'b1) jt_cnt++;
    if (ctick === 1'b1) ct_cnt++;
    if (tick_raw === 1'b1 && code_in[7:6] === CODE_DIST_INT) di_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // two-phase access, held until the edge that takes it
  task automatic bus(input logic [7:0] a, input logic wr,
                     input logic [31:0] d, output logic [31:0] q);
    @(negedge mclk_i);
    psel_i = 1'b1;
    penable_i = 1'b0;
    paddr_i = a;
    pwrite_i = wr;
    pwdata_i = d;
    @(negedge mclk_i);
    penable_i = 1'b1;
    // data is taken at the edge that completes the access
    @(posedge mclk_i);
    q = prdata_o;
    @(negedge mclk_i);
    psel_i = 1'b0;
    penable_i = 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask

  task automatic rd(input string what, input logic [7:0] a,
                    input logic [31:0] exp);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    check(what, {32'h0, exp}, {32'h0, q});
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(negedge mclk_i);
    rst_n_i = 1'b1;
    rd("rate step", OFS_RATE_STEP, 32'h15798EE2);
    rd("time step", OFS_TIME_STEP, 32'h0);
    rd("gain", OFS_GAIN, 32'h1CD);
    rd("status", OFS_STATUS, 32'h0);
    rd("map", OFS_MAP, 32'h6);
    rd("unmapped", 8'hFC, 32'h0);
    wr(OFS_GAIN, 32'h00FFFFFF);
    rd("gain", OFS_GAIN, 32'h00FFFFFF);
    // zero gain keeps the step fixed for the rate checks below
    wr(OFS_GAIN, 32'h0);
    // time-code while disabled is ignored
    codec_model_i.emit(8'h05);
    rd("status", OFS_STATUS, 32'h0);
    check("jtick count", 64'd0, 64'(jt_cnt));
    wr(OFS_CTRL, 32'h1);
    check("enable", 64'd1, {63'h0, en});
    codec_model_i.emit(8'h05);
    rd("status", OFS_STATUS, 32'h2);
    check("jtick count", 64'd1, 64'(jt_cnt));
    wr(OFS_STATUS, 32'h0);
    rd("status", OFS_STATUS, 32'h2);
    wr(OFS_STATUS, 32'h2);
    rd("status", OFS_STATUS, 32'h0);
    codec_model_i.emit(8'h83);
    rd("status", OFS_STATUS, 32'h10);
    check("jtick count", 64'd1, 64'(jt_cnt));
    wr(OFS_STATUS, 32'h10);
    wr(OFS_TLOAD_LO, 32'h100);
    wr(OFS_TLOAD_HI, 32'h0);
    rd("status", OFS_STATUS, 32'h1);
    wr(OFS_STATUS, 32'h1);
    // accumulator wraps every second clock, one unit per wrap
    wr(OFS_TIME_STEP, 32'h1);
    wr(OFS_RATE_STEP, 32'h20000000);
    @(negedge mclk_i);
    e0 = et;
    repeat (20) @(negedge mclk_i);
    check("time advance", 64'd10, 64'(et - e0));
    e0 = et;
    wr(OFS_LATENCY, 32'h5);
    repeat (17) @(negedge mclk_i);
    check("time with latency", 64'd15, 64'(et - e0));
    rd("rate step", OFS_RATE_STEP, 32'h20000000);
    // bit 6 of local time falls every 256 clocks
    c0 = ct_cnt;
    repeat (1024) @(negedge mclk_i);
    check("ctick count", 64'd4, 64'(ct_cnt - c0));
    // queued distributed interrupt, slow codec answer
    lag = 4'h9;
    c0 = di_cnt;
    wr(OFS_CTRL, 32'h3);
    for (i = 0; i < 600 && di_cnt == c0; i++) @(negedge mclk_i);
    // a wait that runs out shows up here as a mismatch
    check("di request", 64'd1, 64'(di_cnt - c0));
    check("di code", {56'h0, CODE_DIST_INT, 6'h00}, {56'h0, code_in});
    repeat (20) @(negedge mclk_i);
    check("di requests", 64'd1, 64'(di_cnt - c0));
    rd("status", OFS_STATUS, 32'h20);
    // unit gain: a late code and a long external period both ask for a
    // slower local rate, so the summed correction turns negative
    wr(OFS_GAIN, 32'h1);
    for (i = 0; i < 300 && ctick !== 1'b1; i++) @(negedge mclk_i);
    check("ctick wait", 64'd1, {63'h0, ctick});
    codec_model_i.emit(8'h07);
    bus(OFS_TRIM, 1'b0, 32'h0, rd_q);
    check("trim sign", 64'd1, {63'h0, rd_q[31]});
    check("jtick count", 64'd2, 64'(jt_cnt));
    // second reset in mid-run restores defaults
    rst_n_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    rst_n_i = 1'b1;
    rd("status", OFS_STATUS, 32'h0);
    rd("gain", OFS_GAIN, 32'h1CD);
    give_verdict();
  end
endmodule
